// [rtl/spr_shift_reg.sv]
`timescale 1ns/1ps
`default_nettype none

module spr_shift_reg
  import spr_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = SPR_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst_n,
  // Operation stream from surrounding logic
  input  wire logic      op_valid,
  input  wire spr_op_t   op,
  output var  logic      op_ready,
  // Direct tail stage outputs
  output var  spr_tail_t tail_stage_outputs,
  output var  logic      serial_out,
  // Buffered tail snapshots
  output var  logic      snap_valid,
  output var  spr_tail_t snap_data,
  input  wire logic      snap_ready
);

  // ------------------------------------------------------------------
  // Operation acceptance
  // ------------------------------------------------------------------
  // A step happens only on an accepted operation; with no operation
  // offered, or the snapshot buffer full, the register holds, so a
  // stalled receiver never misses a tail value.
  logic step;
  logic buf_in_ready;

  assign op_ready = buf_in_ready;
  assign step     = op_valid && buf_in_ready;

  // ------------------------------------------------------------------
  // Stage register
  // ------------------------------------------------------------------
  logic [SPR_STAGES-1:0] stage_r;
  logic [SPR_STAGES-1:0] stage_nxt;

  // Per-stage next value: load, shift or hold
  for (genvar i = 0; i < SPR_STAGES; i++) begin : g_stage
    logic shift_src;
    if (i == 0) begin : g_first
      assign shift_src = op.serial_in;
    end else begin : g_rest
      assign shift_src = stage_r[i-1];
    end
    assign stage_nxt[i] = !step                   ? stage_r[i] :
                          op.parallel_load_select ? op.parallel_inputs[i] :
                                                    shift_src;
  end

  // Stages are deliberately left without reset; a load or eight shifts
  // give them a defined value, exactly as the discrete part behaves.
  always_ff @(posedge clock) begin
    stage_r <= stage_nxt;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Only the three tail stages leave the block
  assign tail_stage_outputs = stage_r[SPR_LAST:SPR_TAIL_LSB];
  assign serial_out         = stage_r[SPR_LAST];

  // Each step pushes the tail it is about to produce
  spr_tail_buf #(
    .WIDTH (SPR_TAIL),
    .DEPTH (BUF_DEPTH)
  ) u_tail_buf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (step),
    .in_data   (stage_nxt[SPR_LAST:SPR_TAIL_LSB]),
    .in_ready  (buf_in_ready),
    .out_valid (snap_valid),
    .out_data  (snap_data),
    .out_ready (snap_ready)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // The stages power up unknown, so every check that compares stage
  // contents with their own earlier values waits until a load, or
  // eight shifts since reset, has written every stage. A mid-run reset
  // mutes those checks until the register is full again, trading a
  // little coverage for never tripping on undefined power-up contents.
  localparam int unsigned   FW        = $clog2(SPR_STAGES + 1);
  localparam logic [FW-1:0] FILL_FULL = FW'(SPR_STAGES);

  logic [FW-1:0] fill_r;
  logic [FW-1:0] fill_nxt;
  logic          stage_known;
  logic          load_step;
  logic          shift_step;

  assign load_step   = step && op.parallel_load_select;
  assign shift_step  = step && !op.parallel_load_select;
  assign stage_known = (fill_r == FILL_FULL);

  // Next fill level: full on a load, one more per shift, saturating
  always_comb begin
    fill_nxt = fill_r;
    if (load_step) begin
      fill_nxt = FILL_FULL;
    end else if (shift_step && !stage_known) begin
      fill_nxt = fill_r + 1'b1;
    end
  end

  // Fill level register; only reset clears it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fill_r <= '0;
    end else begin
      fill_r <= fill_nxt;
    end
  end

  // A load overwrites every stage, defined or not
  load_all_a: assert property (@(posedge clock) disable iff (!rst_n)
    load_step |=> stage_r == $past(op.parallel_inputs))
    else $error("parallel load did not fill all stages");

  // The serial bit lands in the first stage on every shift
  serial_entry_a: assert property (@(posedge clock) disable iff (!rst_n)
    shift_step |=> stage_r[0] == $past(op.serial_in))
    else $error("serial input not captured in first stage");

  // Every stage above the first takes its neighbour's old value
  shift_move_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && shift_step)
    |=> stage_r[SPR_STAGES-1:1] == $past(stage_r[SPR_STAGES-2:0]))
    else $error("stages did not move by one place");

  // Without an accepted step nothing moves
  idle_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && !step) |=> $stable(stage_r))
    else $error("register changed without an accepted step");

  // A refused operation leaves the visible tail alone
  edge_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && op_valid && !op_ready) |=> $stable(tail_stage_outputs))
    else $error("tail moved while operation was refused");

  // Refusal only happens while snapshots are waiting
  refuse_full_a: assert property (@(posedge clock) disable iff (!rst_n)
    !op_ready |-> snap_valid)
    else $error("operation refused with an empty snapshot buffer");

  // A step onto one stalled snapshot fills the buffer and refuses
  ready_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (snap_valid && !snap_ready && step) |=> !op_ready)
    else $error("full snapshot buffer still accepts operations");

  // The tail pins show the loaded top three bits
  tail_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    load_step |=> tail_stage_outputs
                  == $past(op.parallel_inputs[SPR_LAST:SPR_TAIL_LSB]))
    else $error("tail outputs do not show loaded stages");

  // After a shift the tail pins show the three stages below them
  tail_shift_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && shift_step) |=> tail_stage_outputs
                  == $past(stage_r[SPR_LAST-1:SPR_TAIL_LSB-1]))
    else $error("tail outputs did not follow a shift");

  // The serial output shows the last stage after a load
  load_serial_a: assert property (@(posedge clock) disable iff (!rst_n)
    load_step |=> serial_out == $past(op.parallel_inputs[SPR_LAST]))
    else $error("serial output does not show loaded last stage");

  // On a shift the serial output takes the seventh stage
  shift_serial_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && shift_step) |=> serial_out == $past(stage_r[SPR_LAST-1]))
    else $error("serial output did not advance on a shift");

  // A first stage bit reaches the serial output after seven shifts
  serial_drain_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stage_known && shift_step) ##1 shift_step [*6]
    |=> serial_out == $past(stage_r[0], 7))
    else $error("first stage bit not at serial output after seven shifts");

  // A step into an empty buffer is offered one cycle later
  snap_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    (step && !snap_valid) ##1 stage_known
    |-> snap_valid && snap_data == tail_stage_outputs)
    else $error("snapshot does not match new tail");

  // Taking a snapshot always frees room for the next operation
  ready_free_a: assert property (@(posedge clock) disable iff (!rst_n)
    (snap_valid && snap_ready) |=> op_ready)
    else $error("operation still refused after a snapshot was taken");

  // Main scenarios worth seeing at least once
  load_seen_c: cover property (@(posedge clock) disable iff (!rst_n)
    load_step ##1 shift_step [*8]);

  shift_run_c: cover property (@(posedge clock) disable iff (!rst_n)
    shift_step [*8]);

  stall_seen_c: cover property (@(posedge clock) disable iff (!rst_n)
    op_valid && !op_ready);

  drain_seen_c: cover property (@(posedge clock) disable iff (!rst_n)
    (op_valid && !op_ready) ##1 (snap_valid && snap_ready) ##1 step);

endmodule

`default_nettype wire

// [rtl/spr_pkg.sv]
package spr_pkg;

  // ------------------------------------------------------------------
  // Register geometry
  // ------------------------------------------------------------------
  localparam int unsigned SPR_STAGES    = 8;  // Stages in the register
  localparam int unsigned SPR_TAIL      = 3;  // Stages with outputs
  localparam int unsigned SPR_TAIL_LSB  = 5;  // First stage with an output
  localparam int unsigned SPR_LAST      = 7;  // Serial output stage
  localparam int unsigned SPR_BUF_DEPTH = 2;  // Entries in the tail buffer

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  // One clock-edge operation offered by the surrounding logic
  typedef struct packed {
    logic                  parallel_load_select;
    logic                  serial_in;
    logic [SPR_STAGES-1:0] parallel_inputs;
  } spr_op_t;

  // Snapshot of the three tail stages, last stage in the top bit
  typedef logic [SPR_TAIL-1:0] spr_tail_t;

endpackage

// [rtl/spr_tail_buf.sv]
`timescale 1ns/1ps
`default_nettype none

module spr_tail_buf
  import spr_pkg::*;
#(
  parameter int unsigned WIDTH = SPR_TAIL,
  parameter int unsigned DEPTH = SPR_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // Draining side
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  // ------------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------------
  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0]    count_r,  count_nxt;
  logic             push;
  logic             pop;
  logic             ready_r,  ready_nxt;
  logic             valid_r,  valid_nxt;
  logic [WIDTH-1:0] head_r,   head_nxt;

  // Flags and head word are flops of their own, worked out from the next count and
  // next read pointer, so the outputs carry no decode after the clock edge
  assign in_ready  = ready_r;
  assign out_valid = valid_r;
  assign out_data  = head_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointers, count and entry contents
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data;
      wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
    ready_nxt = (count_nxt != CNT_FULL);
    valid_nxt = (count_nxt != '0);
    head_nxt  = mem_nxt[rd_ptr_nxt];
  end

  // Entries carry no reset; only the control state needs one
  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_r[i] <= mem_nxt[i];
    end
    head_r <= head_nxt;
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
      valid_r  <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      ready_r  <= ready_nxt;
      valid_r  <= valid_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  count_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    count_r <= CNT_FULL)
    else $error("buffer count beyond depth");

  full_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!in_ready && !out_ready) |=> !in_ready && $stable(out_data))
    else $error("full buffer changed while drain stalled");

  flag_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    in_ready == (count_r != CNT_FULL) && out_valid == (count_r != '0))
    else $error("buffer flags disagree with the count");

endmodule

`default_nettype wire

// [verif/spr_sink.sv]
`timescale 1ns/1ps
`default_nettype none

// Snapshot receiver; stalls only when the bench asks it to
module spr_sink
  import spr_pkg::*;
(
  // Clock and stall control
  input  wire logic      clock,
  input  wire logic      stall,
  // Snapshot stream
  input  wire logic      snap_valid,
  input  wire spr_tail_t snap_data,
  output var  logic      snap_ready
);
  spr_tail_t got[$];

  // Ready follows the stall request, so no word is taken while stalled
  always_comb snap_ready = !stall;

  // Record every tail snapshot in arrival order
  always @(posedge clock) begin
    if (snap_valid && snap_ready) got.push_back(snap_data);
  end
endmodule

`default_nettype wire

// [verif/sync_8bit_piso_shift_register_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module sync_8bit_piso_shift_register_bench;
  import spr_pkg::*;
  logic       clock, rst_n, op_valid, op_ready, serial_out;
  logic       snap_valid, snap_ready, stall;
  spr_op_t    op;
  spr_tail_t  tail, snap_data, exp_q[$];
  logic [7:0] ref_r, hold_v;
  int         failures, total_checks, cycles;

  spr_shift_reg spr_shift_reg_inst (.clock(clock), .rst_n(rst_n),
    .op_valid(op_valid), .op(op), .op_ready(op_ready),
    .tail_stage_outputs(tail), .serial_out(serial_out),
    .snap_valid(snap_valid), .snap_data(snap_data),
    .snap_ready(snap_ready));
  spr_sink spr_sink_inst (.clock(clock), .stall(stall),
    .snap_valid(snap_valid), .snap_data(snap_data),
    .snap_ready(snap_ready));

  // ------------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // A stuck handshake ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One operation, entered at edge+1; holds until ready seen at the edge
  task automatic do_op(input logic s, input logic d, input logic [7:0] p);
    int n;
    n = 0;
    op = '{s, d, p};
    op_valid = 1'b1;
    #3;
    while (op_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      #4;
      n++;
    end
    @(posedge clock);
    #1;
    ref_r = s ? p : {ref_r[6:0], d};
    exp_q.push_back(ref_r[7:5]);
    cmp({5'h00, tail}, {5'h00, ref_r[7:5]});
    cmp({7'h00, serial_out}, {7'h00, ref_r[7]});
  endtask

  task automatic idle(input int n);
    op_valid = 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Back-to-back loads of complementary patterns
  task automatic t_load();
    do_op(1'b1, 1'b0, 8'hA5);
    do_op(1'b1, 1'b1, 8'h5A);
    idle(1);
  endtask

  // Eight shifts replace the whole register with the serial word
  task automatic t_shift();
    logic [7:0] w;
    w = 8'h3C;
    for (int i = 7; i >= 0; i--) do_op(1'b0, w[i], 8'hFF);
    cmp({5'h00, tail}, {5'h00, w[7:5]});
    idle(1);
  endtask

  // Full buffer refuses a shift; stages must hold meanwhile
  task automatic t_stall();
    stall = 1'b1;
    do_op(1'b1, 1'b0, 8'hC3);
    do_op(1'b0, 1'b1, 8'h00);
    hold_v = ref_r;
    fork
      do_op(1'b0, 1'b0, 8'h00);
      begin
        repeat (3) @(posedge clock);
        #1;
        cmp({5'h00, tail}, {5'h00, hold_v[7:5]});
        cmp({7'h00, op_ready}, 8'h00);
        stall = 1'b0;
      end
    join
    idle(6);
  endtask

  // Snapshots arrive whole and in step order
  task automatic t_drain();
    cmp(8'(spr_sink_inst.got.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) begin
      cmp({5'h00, spr_sink_inst.got[i]}, {5'h00, exp_q[i]});
    end
  endtask

  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op = '0;
    stall = 1'b0;
    ref_r = 8'h00;
    repeat (10) @(posedge clock);
    #1;
    cmp({6'h00, op_ready, snap_valid}, 8'h02);
    rst_n = 1'b1;
    t_load();
    t_shift();
    t_stall();
    t_drain();
    summarize();
  end
endmodule

`default_nettype wire
